// ---- fbp_flash_ctrl.sv ----
// Flash array controller with block erase and per-region protection
`timescale 1ns/1ps

module fbp_flash_ctrl #(
	parameter int FLASH_BYTES = 131072
) (
	input  wire logic                  i_clk_sys,   // System clock, 100 MHz
	input  wire logic                  i_rst_n,     // Synchronous reset, active low
	input  wire fbp_pkg::fbp_rd_req_t  i_fetch,     // Instruction fetch request
	output      fbp_pkg::fbp_rd_rsp_t  o_fetch,     // Instruction fetch answer
	input  wire fbp_pkg::fbp_rd_req_t  i_data,      // Data or debug read request
	output      fbp_pkg::fbp_rd_rsp_t  o_data,      // Data or debug read answer
	input  wire fbp_pkg::fbp_cmd_t     i_cmd,       // Program or erase command
	output      logic                  o_cmd_ready, // Command may be taken
	output      logic                  o_cmd_done,  // Command finished, pulse
	output      logic                  o_cmd_rej,   // Command refused, pulse
	output      logic                  o_busy,      // Erase in progress
	input  wire fbp_pkg::fbp_prot_wr_t i_prot,      // Protection setting write
	output      logic                  o_viol,      // Sticky access violation
	input  wire logic                  i_viol_clr   // Clears the violation flag
);
	import fbp_pkg::*;

	// ------------------------------------------------------------
	// Elaboration checks
	// ------------------------------------------------------------
	localparam int WORDS_P = FLASH_BYTES / FB_WORD_BYTES;

	if (FLASH_BYTES > FB_FLASH_BYTES || FLASH_BYTES < FB_PROT_BYTES ||
	    (FLASH_BYTES % FB_PROT_BYTES) != 0) begin : g_bad_size
		$error("FLASH_BYTES must be whole regions and no larger than the array");
	end

	// ------------------------------------------------------------
	// Helper functions
	// ------------------------------------------------------------
	// Region that holds a word address
	function automatic logic [FB_REGION_W-1:0] region_of(input logic [FB_ADDR_W-1:0] a);
		return a[FB_ADDR_W-1 -: FB_REGION_W];
	endfunction

	// Address falls inside the populated array
	function automatic logic in_range(input logic [FB_ADDR_W-1:0] a);
		return 32'(a) < WORDS_P;
	endfunction

	// Mode refuses program and erase
	function automatic logic no_write(input fbp_prot_t m);
		return m != FBP_PROT_OPEN;
	endfunction

	// Mode refuses data and debug reads
	function automatic logic no_data_rd(input fbp_prot_t m);
		return m == FBP_PROT_XO || m == FBP_PROT_RSVD;
	endfunction

	// ------------------------------------------------------------
	// Storage
	// ------------------------------------------------------------
	logic [FB_DATA_W-1:0]  mem [0:FB_WORDS-1];   // Flash array
	fbp_prot_t             prot [0:FB_REGIONS-1];

	fbp_state_t            state;
	fbp_state_t            next_state;
	logic [FB_BLOCK_W-1:0] erase_blk;
	logic [FB_CNT_W-1:0]   erase_cnt;

	logic                  cmd_take;
	logic                  cmd_ok;
	logic                  cmd_deny;
	logic                  data_deny;
	logic                  data_oor;
	logic                  fetch_oor;
	logic                  viol_set;
	fbp_prot_t             cmd_mode;

	// ------------------------------------------------------------
	// Command decode
	// ------------------------------------------------------------
	// Command port is free only while no erase runs
	assign o_cmd_ready = (state == FBP_ST_IDLE);
	assign o_busy      = (state == FBP_ST_ERASE);
	assign cmd_take    = i_cmd.valid && o_cmd_ready;
	assign cmd_mode    = prot[region_of(i_cmd.addr)];
	// Protected or absent target refuses both program and erase
	assign cmd_deny    = cmd_take && (no_write(cmd_mode) || !in_range(i_cmd.addr));
	assign cmd_ok      = cmd_take && !cmd_deny;

	// Read denial checks
	assign data_oor    = !in_range(i_data.addr);
	assign fetch_oor   = !in_range(i_fetch.addr);
	assign data_deny   = i_data.valid && !data_oor &&
	                     no_data_rd(prot[region_of(i_data.addr)]);

	// Only protection refusals raise the flag
	assign viol_set    = data_deny || (cmd_take && no_write(cmd_mode) &&
	                     in_range(i_cmd.addr));

	// ------------------------------------------------------------
	// Erase sequencer
	// ------------------------------------------------------------
	// Next state selection
	always_comb begin
		next_state = state;
		case (state)
			FBP_ST_IDLE: begin
				if (cmd_ok && i_cmd.op == FBP_OP_ERASE) begin
					next_state = FBP_ST_ERASE;
				end
			end
			FBP_ST_ERASE: begin
				if (erase_cnt == FB_CNT_LAST) begin
					next_state = FBP_ST_IDLE;
				end
			end
			default: begin
				next_state = FBP_ST_IDLE;
			end
		endcase
	end

	// State register
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			state <= FBP_ST_IDLE;
		end else begin
			state <= next_state;
		end
	end

	// Block latch and word counter of the running erase
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			erase_blk <= '0;
			erase_cnt <= '0;
		end else if (state == FBP_ST_IDLE) begin
			erase_cnt <= '0;
			if (cmd_ok && i_cmd.op == FBP_OP_ERASE) begin
				erase_blk <= i_cmd.addr[FB_ADDR_W-1 -: FB_BLOCK_W];
			end
		end else begin
			erase_cnt <= erase_cnt + 1'b1;
		end
	end

	// ------------------------------------------------------------
	// Array writes
	// ------------------------------------------------------------
	// Program clears bits only; erase fills one block word by word
	always_ff @(posedge i_clk_sys) begin
		if (state == FBP_ST_ERASE) begin
			mem[{erase_blk, erase_cnt}] <= FB_ERASED;
		end else if (cmd_ok && i_cmd.op == FBP_OP_PROGRAM) begin
			mem[i_cmd.addr] <= mem[i_cmd.addr] & i_cmd.data;
		end
	end

	// Completion and refusal pulses
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			o_cmd_done <= 1'b0;
			o_cmd_rej  <= 1'b0;
		end else begin
			o_cmd_done <= (cmd_ok && i_cmd.op == FBP_OP_PROGRAM) ||
			              (state == FBP_ST_ERASE && erase_cnt == FB_CNT_LAST);
			o_cmd_rej  <= cmd_deny;
		end
	end

	// ------------------------------------------------------------
	// Protection settings
	// ------------------------------------------------------------
	// One mode per 2 KB region, all open after reset
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			for (int r = 0; r < FB_REGIONS; r++) begin
				prot[r] <= FBP_PROT_OPEN;
			end
		end else if (i_prot.wr) begin
			prot[i_prot.region] <= i_prot.mode;
		end
	end

	// ------------------------------------------------------------
	// Read ports
	// ------------------------------------------------------------
	// Fetch answers next cycle in every protection mode
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			o_fetch.valid  <= 1'b0;
			o_fetch.denied <= 1'b0;
			o_fetch.data   <= FB_RD_RESET;
		end else begin
			o_fetch.valid  <= i_fetch.valid;
			o_fetch.denied <= i_fetch.valid && fetch_oor;
			o_fetch.data   <= (i_fetch.valid && !fetch_oor) ?
			                  mem[i_fetch.addr] : FB_RD_RESET;
		end
	end

	// Data and debug reads answer next cycle, blanked when denied
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			o_data.valid  <= 1'b0;
			o_data.denied <= 1'b0;
			o_data.data   <= FB_RD_RESET;
		end else begin
			o_data.valid  <= i_data.valid;
			o_data.denied <= i_data.valid && (data_deny || data_oor);
			o_data.data   <= (i_data.valid && !data_deny && !data_oor) ?
			                 mem[i_data.addr] : FB_RD_RESET;
		end
	end

	// ------------------------------------------------------------
	// Violation flag
	// ------------------------------------------------------------
	// Sticky; a new violation wins over a clear in the same cycle
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			o_viol <= 1'b0;
		end else if (viol_set) begin
			o_viol <= 1'b1;
		end else if (i_viol_clr) begin
			o_viol <= 1'b0;
		end
	end

endmodule

// ---- fbp_pkg.sv ----
// Constants, types and state codes for the flash block protection controller
//
// What this block does
// - Holds a 128 KB flash array that the processor addresses.
// - Every read or fetch answers one cycle later, with no wait states.
// - Array splits into 1 KB erase blocks, each erased on its own.
// - After an erase every bit of the erased block reads as one.
// - Two adjacent erase blocks form a 2 KB region with its own protection.
// - Each region is unprotected, read-only or execute-only.
// - Read-only regions refuse erase and program but still allow reads.
// - Execute-only regions refuse erase and program as well.
// - Execute-only regions answer instruction fetches only, never data or debug reads.
package fbp_pkg;

	// ------------------------------------------------------------
	// Array geometry
	// ------------------------------------------------------------
	localparam int FB_FLASH_BYTES  = 131072;   // 128 KB array
	localparam int FB_WORD_BYTES   = 4;
	localparam int FB_ERASE_BYTES  = 1024;     // One erase block
	localparam int FB_PROT_BYTES   = 2048;     // One protection region
	localparam int FB_WORDS        = FB_FLASH_BYTES / FB_WORD_BYTES;
	localparam int FB_BLK_WORDS    = FB_ERASE_BYTES / FB_WORD_BYTES;
	localparam int FB_REG_WORDS    = FB_PROT_BYTES / FB_WORD_BYTES;
	localparam int FB_ADDR_W       = $clog2(FB_WORDS);
	localparam int FB_CNT_W        = $clog2(FB_BLK_WORDS);
	localparam int FB_BLOCK_W      = FB_ADDR_W - FB_CNT_W;
	localparam int FB_REGION_W     = FB_ADDR_W - $clog2(FB_REG_WORDS);
	localparam int FB_REGIONS      = FB_WORDS / FB_REG_WORDS;
	localparam int FB_DATA_W       = 32;

	// ------------------------------------------------------------
	// Reset and fill values
	// ------------------------------------------------------------
	localparam logic [FB_DATA_W-1:0] FB_ERASED   = 32'hffffffff;
	localparam logic [FB_DATA_W-1:0] FB_RD_RESET = 32'h00000000;
	localparam logic [FB_CNT_W-1:0]  FB_CNT_LAST = FB_CNT_W'(FB_BLK_WORDS - 1);

	// ------------------------------------------------------------
	// Protection modes and commands
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		FBP_PROT_OPEN  = 2'h0,
		FBP_PROT_RO    = 2'h1,
		FBP_PROT_XO    = 2'h2,
		FBP_PROT_RSVD  = 2'h3
	} fbp_prot_t;

	typedef enum logic {
		FBP_OP_PROGRAM = 1'h0,
		FBP_OP_ERASE   = 1'h1
	} fbp_op_t;

	typedef enum logic [1:0] {
		FBP_ST_IDLE  = 2'h1,
		FBP_ST_ERASE = 2'h2
	} fbp_state_t;

	// ------------------------------------------------------------
	// Carriers
	// ------------------------------------------------------------
	typedef struct packed {
		logic                 valid;
		logic                 debug;    // Read comes from the debugger
		logic [FB_ADDR_W-1:0] addr;     // Word address
	} fbp_rd_req_t;

	typedef struct packed {
		logic                 valid;
		logic                 denied;
		logic [FB_DATA_W-1:0] data;
	} fbp_rd_rsp_t;

	typedef struct packed {
		logic                 valid;
		fbp_op_t              op;
		logic [FB_ADDR_W-1:0] addr;     // Word address; erase uses its block
		logic [FB_DATA_W-1:0] data;
	} fbp_cmd_t;

	typedef struct packed {
		logic                   wr;
		logic [FB_REGION_W-1:0] region;
		fbp_prot_t              mode;
	} fbp_prot_wr_t;

endpackage

// ---- fbp_flash_ctrl_chk.sv ----
// Port assertions for the flash protection controller
`timescale 1ns/1ps
module fbp_flash_ctrl_chk #(
	parameter int FLASH_BYTES = 131072
) (
	input wire logic                 i_clk_sys,   // Clock
	input wire logic                 i_rst_n,     // Reset, active low
	input wire fbp_pkg::fbp_rd_req_t i_fetch,     // Fetch request
	input wire fbp_pkg::fbp_rd_rsp_t o_fetch,     // Fetch answer
	input wire fbp_pkg::fbp_rd_req_t i_data,      // Data request
	input wire fbp_pkg::fbp_rd_rsp_t o_data,      // Data answer
	input wire fbp_pkg::fbp_cmd_t    i_cmd,       // Command
	input wire logic                 o_cmd_ready, // Command ready
	input wire logic                 o_cmd_done,  // Command done
	input wire logic                 o_cmd_rej,   // Command refused
	input wire logic                 o_busy,      // Erase running
	input wire logic                 o_viol,      // Violation flag
	input wire logic                 i_viol_clr   // Flag clear
);
	import fbp_pkg::*;
	default clocking @(posedge i_clk_sys); endclocking
	default disable iff (!i_rst_n);
	// Erase accepted and running
	sequence s_erase_go;
		i_cmd.valid && o_cmd_ready && i_cmd.op == FBP_OP_ERASE ##1 o_busy;
	endsequence
	a_erase_length: assert property (s_erase_go |-> ##256 (!o_busy && o_cmd_done))
		else $error("erase length wrong");
	a_busy_blocks: assert property (o_busy |-> !o_cmd_ready && !o_cmd_done)
		else $error("busy overlaps ready or done");
	a_fetch_answer: assert property (i_fetch.valid |=> o_fetch.valid)
		else $error("fetch answer late");
	a_data_answer: assert property (i_data.valid |=> o_data.valid)
		else $error("data answer late");
	a_fetch_free: assert property (o_fetch.denied |-> $past(i_fetch.addr) >= FLASH_BYTES / 4)
		else $error("fetch refused in range");
	a_deny_empty: assert property (o_data.denied |-> o_data.data == '0)
		else $error("denied read carries data");
	a_viol_hold: assert property (o_viol && !i_viol_clr |=> o_viol)
		else $error("violation flag dropped");
	a_viol_cause: assert property ($rose(o_viol) |-> o_data.denied || o_cmd_rej)
		else $error("violation without refusal");
	a_prog_once: assert property (i_cmd.valid && o_cmd_ready && i_cmd.op == FBP_OP_PROGRAM
		|=> o_cmd_done != o_cmd_rej)
		else $error("program outcome wrong");
endmodule
bind fbp_flash_ctrl fbp_flash_ctrl_chk #(.FLASH_BYTES(FLASH_BYTES)) CHK (
	.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_fetch(i_fetch), .o_fetch(o_fetch),
	.i_data(i_data), .o_data(o_data), .i_cmd(i_cmd), .o_cmd_ready(o_cmd_ready),
	.o_cmd_done(o_cmd_done), .o_cmd_rej(o_cmd_rej), .o_busy(o_busy), .o_viol(o_viol),
	.i_viol_clr(i_viol_clr));

// ---- fbp_bus_model.sv ----
// Processor and debugger read requester
`timescale 1ns/1ps
module fbp_bus_model (
	input  wire logic                 i_clk_sys, // Clock
	input  wire fbp_pkg::fbp_rd_rsp_t i_fetch,   // Fetch answer
	input  wire fbp_pkg::fbp_rd_rsp_t i_data,    // Data answer
	output fbp_pkg::fbp_rd_req_t      o_fetch,   // Fetch request
	output fbp_pkg::fbp_rd_req_t      o_data     // Data or debug request
);
	import fbp_pkg::*;
	initial o_fetch = '0;
	initial o_data = '0;
	// One request, answer taken one cycle later, address scrambled on release
	task automatic read(input logic f, input logic d, input logic [FB_ADDR_W-1:0] a,
		output fbp_rd_rsp_t r);
		@(posedge i_clk_sys);
		if (f) o_fetch <= '{1'b1, 1'b0, a};
		else o_data <= '{1'b1, d, a};
		@(posedge i_clk_sys);
		o_fetch <= '{1'b0, 1'b0, ~a};
		o_data <= '{1'b0, 1'b0, ~a};
		#1 r = f ? i_fetch : i_data;
	endtask
endmodule

// ---- fbp_flash_ctrl_tb.sv ----
// Self-checking bench for the flash protection controller
`timescale 1ns/1ps
module fbp_flash_ctrl_tb;
	import fbp_pkg::*;
	localparam int WORDS = 1024;    // Four erase blocks, two regions
	logic         i_clk_sys, i_rst_n, i_viol_clr, viol_m;
	logic         o_cmd_ready, o_cmd_done, o_cmd_rej, o_busy, o_viol;
	fbp_rd_req_t  i_fetch, i_data;
	fbp_rd_rsp_t  o_fetch, o_data, r;
	fbp_cmd_t     i_cmd;
	fbp_prot_wr_t i_prot;
	logic [31:0]  mem [WORDS];
	logic [1:0]   prot [2];
	logic [14:0]  a;
	int           n_errors, comparisons, cycles, i, m;
	fbp_flash_ctrl #(.FLASH_BYTES(WORDS * 4)) DUT (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n),
		.i_fetch(i_fetch), .o_fetch(o_fetch), .i_data(i_data), .o_data(o_data),
		.i_cmd(i_cmd), .o_cmd_ready(o_cmd_ready), .o_cmd_done(o_cmd_done),
		.o_cmd_rej(o_cmd_rej), .o_busy(o_busy), .i_prot(i_prot), .o_viol(o_viol),
		.i_viol_clr(i_viol_clr));
	fbp_bus_model BUS (.i_clk_sys(i_clk_sys), .i_fetch(o_fetch), .i_data(o_data),
		.o_fetch(i_fetch), .o_data(i_data));
	initial begin
		i_clk_sys = 1'b0;
		forever #5 i_clk_sys = ~i_clk_sys;
	end
	// Hang guard
	always @(posedge i_clk_sys) begin
		cycles++;
		if (cycles == 8000) begin
			n_errors++;
			end_sim();
		end
	end
	task end_sim;
		$display("errors %0d comparisons %0d", n_errors, comparisons);
		if (n_errors == 0 && comparisons > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	task chk(input logic [33:0] seen, input logic [33:0] exp, input string what);
		comparisons++;
		if (seen !== exp) begin
			n_errors++;
			$display("[FAIL] %0t %s seen %h exp %h", $time, what, seen, exp);
		end
	endtask
	function automatic logic [33:0] exp_rd(input logic f, input logic [14:0] ad);
		if (ad >= WORDS || (!f && prot[ad[9]] >= 2'h2)) return {2'b11, 32'h0};
		return {2'b10, mem[ad]};
	endfunction
	task rd(input logic f, input logic d, input logic [14:0] ad);
		viol_m = viol_m | (!f && ad < WORDS && prot[ad[9]] >= 2'h2);
		BUS.read(f, d, ad, r);
		chk(r, exp_rd(f, ad), "read");
		chk(o_viol, viol_m, "read flag");
	endtask
	task cmd(input fbp_op_t op, input logic [14:0] ad, input logic [31:0] d);
		logic rej;
		int k;
		rej = ad >= WORDS || prot[ad[9]] != 2'h0;
		@(posedge i_clk_sys);
		i_cmd <= '{1'b1, op, ad, d};
		@(posedge i_clk_sys);
		i_cmd <= '{1'b0, op, ~ad, ~d};
		#1 chk(o_cmd_rej, rej, "refusal");
		if (!rej && op == FBP_OP_ERASE) begin
			chk({o_busy, o_cmd_ready}, 2'b10, "erase busy");
			for (k = 0; k < 300 && !o_cmd_done; k++) @(posedge i_clk_sys) #1;
			chk(k, 256, "erase cycles");
			chk({o_busy, o_cmd_ready}, 2'b01, "erase over");
			for (k = 0; k < 256; k++) mem[ad[9:8] * 256 + k] = FB_ERASED;
		end else if (!rej) begin
			chk(o_cmd_done, 1'b1, "program done");
			mem[ad] = mem[ad] & d;
		end
		viol_m = viol_m | (rej && ad < WORDS);
		chk(o_viol, viol_m, "command flag");
	endtask
	task setp(input logic rg, input logic [1:0] md);
		@(posedge i_clk_sys);
		i_prot <= '{1'b1, 6'(rg), fbp_prot_t'(md)};
		prot[rg] = md;
		@(posedge i_clk_sys);
		i_prot.wr <= 1'b0;
	endtask
	task clr;
		@(posedge i_clk_sys);
		i_viol_clr <= 1'b1;
		@(posedge i_clk_sys);
		i_viol_clr <= 1'b0;
		viol_m = 1'b0;
		#1 chk(o_viol, 1'b0, "clear");
	endtask
	// Main sequence
	initial begin
		{i_rst_n, i_viol_clr, viol_m, i_cmd, i_prot} = '0;
		prot = '{2'h0, 2'h0};
		void'($urandom(32'h5d17));
		repeat (6) @(posedge i_clk_sys);
		i_rst_n <= 1'b1;
		@(posedge i_clk_sys);
		#1 chk({o_cmd_ready, o_busy, o_viol}, 3'b100, "reset");
		// Erase all, spot-check ones on both ports
		for (i = 0; i < 4; i++) cmd(FBP_OP_ERASE, i * 256 + $urandom_range(255), $urandom);
		for (i = 0; i < 8; i++) rd(i[0], 1'b0, $urandom_range(WORDS - 1));
		// Random programs read back at once
		for (i = 0; i < 20; i++) begin
			a = $urandom_range(WORDS - 1);
			cmd(FBP_OP_PROGRAM, a, $urandom);
			rd(1'b1, 1'b0, a);
			rd(1'b0, i[0], a);
		end
		// One block erased, the others keep their words
		cmd(FBP_OP_ERASE, 15'h100, 32'h0);
		for (i = 0; i < 4; i++) rd(1'b0, 1'b0, i * 256 + 7);
		// Every mode on region 1 while region 0 stays open
		for (m = 0; m < 4; m++) begin
			setp(1'b1, m[1:0]);
			a = 512 + $urandom_range(511);
			cmd(FBP_OP_PROGRAM, a, 32'h0);
			cmd(FBP_OP_ERASE, a, 32'h0);
			rd(1'b1, 1'b0, a);
			rd(1'b0, 1'b0, a);
			rd(1'b0, 1'b1, a);
			cmd(FBP_OP_PROGRAM, $urandom_range(511), $urandom);
			if (m >= 2) begin
				// Clear held across a refused read: the new violation must win
				@(posedge i_clk_sys);
				i_viol_clr <= 1'b1;
				rd(1'b0, 1'b1, a);
				@(posedge i_clk_sys);
				i_viol_clr <= 1'b0;
				viol_m = 1'b0;
			end
			clr();
		end
		// Out of range, refused without a flag
		rd(1'b0, 1'b0, 15'h7fff);
		rd(1'b1, 1'b0, WORDS);
		cmd(FBP_OP_PROGRAM, WORDS, 32'h0);
		end_sim();
	end
endmodule
